// [xbed_regs.vh]
//
// Function
// - decode jump-if-no-overflow and jump-if-not-sign short jumps, 4 or 13 clocks
// - jump-if-count-zero branches only when count register is zero, 5 or 15 clocks
// - loop decrements count and branches while non-zero, 6 or 16 clocks
// - loop-while-zero / not-zero also test zero flag, 6 or 16 clocks
// - interrupt-on-overflow raises interrupt only if overflow set, 48 or 4 clocks
// - bounds check with mode byte, register against memory range, 33 to 35 clocks
// - bus lock prefix asserts lock for next instruction, costs 2 clocks
// - effective address takes 4 clocks, included in instruction counts
// - mode 11 makes the register/memory field a second register selector
// - mode 00 no disp, mode 01 sign-extended byte, mode 10 full word
// - codes 000-011 add base, index and displacement
// - codes 100-111 add displacement to one register: si, di, bp, bx
// - mode 00 with code 110 uses the displacement word directly
// - displacement bytes follow the second byte, before immediate data
// - segment override prefix 001 ss 110 picks es, cs, ss, ds
// - register field picks word registers, or low then high bytes
// - frame-pointer-based operands default to the stack segment
// - string destinations via destination index always use extra segment
//
`ifndef XBED_REGS_VH
`define XBED_REGS_VH
// opcodes
`define XBED_OP_JNOVF   8'h71
`define XBED_OP_JNSIGN  8'h79
`define XBED_OP_JCZ     8'hE3
`define XBED_OP_LOOP    8'hE2
`define XBED_OP_LOOPZ   8'hE1
`define XBED_OP_LOOPNZ  8'hE0
`define XBED_OP_INTOVF  8'hCE
`define XBED_OP_BOUND   8'h62
`define XBED_OP_LOCK    8'hF0
// segment override prefix pattern
`define XBED_SEG_MASK   8'hE7
`define XBED_SEG_PAT    8'h26
// field positions in the mode byte
`define XBED_MOD_HI     7
`define XBED_MOD_LO     6
`define XBED_REG_HI     5
`define XBED_REG_LO     3
`define XBED_RM_HI      2
`define XBED_RM_LO      0
// segment selector codes
`define XBED_SEG_ES     2'h0
`define XBED_SEG_CS     2'h1
`define XBED_SEG_SS     2'h2
`define XBED_SEG_DS     2'h3
// clock counts: not taken / taken
`define XBED_T_JCC_NT   8'h04
`define XBED_T_JCC_TK   8'h0D
`define XBED_T_JCZ_NT   8'h05
`define XBED_T_JCZ_TK   8'h0F
`define XBED_T_LOOP_NT  8'h06
`define XBED_T_LOOP_TK  8'h10
`define XBED_T_INTERRUPT_ON_OVERFLOW_TK  8'h30
`define XBED_T_INTERRUPT_ON_OVERFLOW_NT  8'h04
`define XBED_T_BOUND_IN 8'h21
`define XBED_T_BOUND_LO 8'h23
`define XBED_T_LOCK     8'h02
`define XBED_T_EA       8'h04
`define XBED_T_OTHER    8'h02
`endif

// [xbed_ea_calc.v]
`timescale 1ns/1ps
`include "xbed_regs.vh"
// --------------------------------------------------------------
// effective address and default segment from mode byte
// --------------------------------------------------------------
module xbed_ea_calc (
   input  wire [7:0]  modrm_in,      // mode/reg/rm byte
   input  wire [7:0]  disp_lo_in,    // low displacement byte
   input  wire [7:0]  disp_hi_in,    // high displacement byte
   input  wire [15:0] bx_in,         // base register
   input  wire [15:0] bp_in,         // frame pointer
   input  wire [15:0] si_in,         // source index
   input  wire [15:0] di_in,         // destination index
   output reg  [15:0] ea_out,        // effective address
   output reg  [1:0]  seg_out,       // default segment
   output wire        is_reg_out     // operand is a register
);
   wire [1:0] mode = modrm_in[`XBED_MOD_HI:`XBED_MOD_LO];
   wire [2:0] rm   = modrm_in[`XBED_RM_HI:`XBED_RM_LO];
   reg  [15:0] disp;
   reg  [15:0] base;

   assign is_reg_out = (mode == 2'h3);

   // displacement sizing
   always @* begin
      case (mode)
         2'h1:    disp = {{8{disp_lo_in[7]}}, disp_lo_in};
         2'h2:    disp = {disp_hi_in, disp_lo_in};
         default: disp = 16'h0000;
      endcase
   end

   // base and index sum; bp forms use the stack segment
   always @* begin
      seg_out = `XBED_SEG_DS;
      case (rm)
         3'h0: base = bx_in + si_in;
         3'h1: base = bx_in + di_in;
         3'h2: begin
            base    = bp_in + si_in;
            seg_out = `XBED_SEG_SS;
         end
         3'h3: begin
            base    = bp_in + di_in;
            seg_out = `XBED_SEG_SS;
         end
         3'h4: base = si_in;
         3'h5: base = di_in;
         3'h6: begin
            base    = bp_in;
            seg_out = `XBED_SEG_SS;
         end
         default: base = bx_in;
      endcase
      if (mode == 2'h0 && rm == 3'h6) begin
         base    = 16'h0000;
         seg_out = `XBED_SEG_DS;
      end
   end

   // direct address takes the word from the displacement slot
   always @* begin
      if (mode == 2'h0 && rm == 3'h6)
         ea_out = {disp_hi_in, disp_lo_in};
      else
         ea_out = base + disp;
   end
endmodule // xbed_ea_calc

// [xbed_decoder.v]
`timescale 1ns/1ps
`include "xbed_regs.vh"
// --------------------------------------------------------------
// branch / address decoder: one byte per clock from program memory
// --------------------------------------------------------------
module xbed_decoder (
   input  wire        clk_in,          // 10 MHz clock
   input  wire        rstn_in,         // async reset, active low
   input  wire [7:0]  byte_in,         // instruction byte
   input  wire        byte_valid_in,   // byte present
   output wire        byte_ready_out,  // byte taken this clock
   input  wire [15:0] cx_in,           // count register value
   input  wire [15:0] bx_in,           // base register
   input  wire [15:0] bp_in,           // frame pointer
   input  wire [15:0] si_in,           // source index
   input  wire [15:0] di_in,           // destination index
   input  wire [15:0] bound_val_in,    // register under bounds check
   input  wire [15:0] bound_lo_in,     // lower bound from memory
   input  wire [15:0] bound_hi_in,     // upper bound from memory
   input  wire        zf_in,           // zero flag
   input  wire        of_in,           // overflow flag
   input  wire        sf_in,           // sign flag
   input  wire        string_dst_in,   // operand is a string destination
   input  wire        byte_op_in,      // w = 0 byte operation
   output reg         done_out,        // instruction finished, one pulse
   output reg  [7:0]  opcode_out,      // decoded opcode
   output reg  [7:0]  clocks_out,      // clocks charged
   output reg         taken_out,       // branch or trap taken
   output reg  [15:0] disp_out,        // sign-extended branch displacement
   output reg         cx_we_out,       // write back decremented count
   output reg  [15:0] cx_new_out,      // decremented count
   output reg         interrupt_on_overflow_trap_out,   // overflow interrupt raised
   output reg         bound_trap_out,  // value out of range
   output reg         lock_out,        // bus lock for the instruction
   output reg  [15:0] ea_out,          // effective address
   output reg  [1:0]  seg_out,         // segment register used
   output reg         rm_is_reg_out,   // second operand is a register
   output reg  [3:0]  reg_sel_out,     // {high byte, word index}
   output reg  [3:0]  rm_sel_out       // register from rm field
);
   // states
   localparam S_OP    = 6'h01;
   localparam S_DISP8 = 6'h02;
   localparam S_MODRM = 6'h04;
   localparam S_DLO   = 6'h08;
   localparam S_DHI   = 6'h10;
   localparam S_WAIT  = 6'h20;

   reg [5:0]  state_q, state_d;
   reg [7:0]  op_q;
   reg [7:0]  modrm_q;
   reg [7:0]  dlo_q;
   reg [7:0]  dhi_q;
   reg        lock_q;
   reg        segovr_q;
   reg [1:0]  segsel_q;
   reg [7:0]  wait_q;

   wire [15:0] ea_w;
   wire [1:0]  seg_w;
   wire        isreg_w;

   // --------------------------------------------------------------
   // address calculation
   // --------------------------------------------------------------
   xbed_ea_calc u_ea (
      .modrm_in   (modrm_q),
      .disp_lo_in (dlo_q),
      .disp_hi_in (dhi_q),
      .bx_in      (bx_in),
      .bp_in      (bp_in),
      .si_in      (si_in),
      .di_in      (di_in),
      .ea_out     (ea_w),
      .seg_out    (seg_w),
      .is_reg_out (isreg_w)
   );

   // byte stream is stalled while the cycle count runs down
   assign byte_ready_out = (state_q != S_WAIT);
   wire take = byte_valid_in && byte_ready_out;

   wire [1:0] mode_b = byte_in[`XBED_MOD_HI:`XBED_MOD_LO];
   wire [2:0] rm_b   = byte_in[`XBED_RM_HI:`XBED_RM_LO];
   wire       dir_b  = (mode_b == 2'h0) && (rm_b == 3'h6);
   wire [15:0] cx_dec = cx_in - 16'h0001;
   wire       is_br  = (op_q == `XBED_OP_JNOVF) || (op_q == `XBED_OP_JNSIGN) ||
                       (op_q == `XBED_OP_JCZ) || (op_q == `XBED_OP_LOOP) ||
                       (op_q == `XBED_OP_LOOPZ) || (op_q == `XBED_OP_LOOPNZ);

   // branch condition and clocks for the short-displacement group
   reg        br_tk;
   reg [7:0]  br_nt, br_t;
   always @* begin
      br_tk = 1'b0;
      br_nt = `XBED_T_JCC_NT;
      br_t  = `XBED_T_JCC_TK;
      case (op_q)
         `XBED_OP_JNOVF:  br_tk = !of_in;
         `XBED_OP_JNSIGN: br_tk = !sf_in;
         `XBED_OP_JCZ: begin
            br_tk = (cx_in == 16'h0000);
            br_nt = `XBED_T_JCZ_NT;
            br_t  = `XBED_T_JCZ_TK;
         end
         `XBED_OP_LOOP: begin
            br_tk = (cx_dec != 16'h0000);
            br_nt = `XBED_T_LOOP_NT;
            br_t  = `XBED_T_LOOP_TK;
         end
         `XBED_OP_LOOPZ: begin
            br_tk = (cx_dec != 16'h0000) && zf_in;
            br_nt = `XBED_T_LOOP_NT;
            br_t  = `XBED_T_LOOP_TK;
         end
         `XBED_OP_LOOPNZ: begin
            br_tk = (cx_dec != 16'h0000) && !zf_in;
            br_nt = `XBED_T_LOOP_NT;
            br_t  = `XBED_T_LOOP_TK;
         end
         default: br_tk = 1'b0;
      endcase
   end

   // bounds test on the finished modrm; register form counts 33, memory 35
   wire       bnd_out = ($signed(bound_val_in) < $signed(bound_lo_in)) ||
                        ($signed(bound_val_in) > $signed(bound_hi_in));
   wire [7:0] bnd_clk = isreg_w ? `XBED_T_BOUND_IN : `XBED_T_BOUND_LO;

   // --------------------------------------------------------------
   // sequencer
   // --------------------------------------------------------------
   reg        fin;      // instruction completes on this byte
   always @* begin
      state_d = state_q;
      fin     = 1'b0;
      case (state_q)
         S_OP: if (take) begin
            if (byte_in == `XBED_OP_LOCK || (byte_in & `XBED_SEG_MASK) == `XBED_SEG_PAT)
               state_d = S_WAIT;
            else if (byte_in == `XBED_OP_BOUND)
               state_d = S_MODRM;
            else if (byte_in[7:4] == 4'h7 || byte_in[7:2] == 6'h38)
               state_d = S_DISP8;
            else begin
               state_d = S_WAIT;
               fin     = 1'b1;
            end
         end
         S_DISP8: if (take) begin
            state_d = S_WAIT;
            fin     = 1'b1;
         end
         S_MODRM: if (take) begin
            // displacement follows the mode byte directly
            if (mode_b == 2'h1 || mode_b == 2'h2 || dir_b)
               state_d = S_DLO;
            else begin
               state_d = S_WAIT;
               fin     = 1'b1;
            end
         end
         S_DLO: if (take) begin
            if (modrm_q[7:6] == 2'h2 || (modrm_q[7:6] == 2'h0))
               state_d = S_DHI;
            else begin
               state_d = S_WAIT;
               fin     = 1'b1;
            end
         end
         S_DHI: if (take) begin
            state_d = S_WAIT;
            fin     = 1'b1;
         end
         S_WAIT: if (wait_q <= 8'h01)
            state_d = S_OP;
         default: state_d = S_OP;
      endcase
   end

   // state and byte capture
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q  <= S_OP;
         op_q     <= 8'h00;
         modrm_q  <= 8'h00;
         dlo_q    <= 8'h00;
         dhi_q    <= 8'h00;
         lock_q   <= 1'b0;
         segovr_q <= 1'b0;
         segsel_q <= 2'h0;
         wait_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         // prefixes apply to one instruction only; cleared ahead of the capture
         // below so a prefix taken on the completion edge still lands
         if (done_out) begin
            lock_q   <= 1'b0;
            segovr_q <= 1'b0;
         end
         if (state_q == S_OP && take) begin
            op_q <= byte_in;
            if (byte_in == `XBED_OP_LOCK)
               lock_q <= 1'b1;
            if ((byte_in & `XBED_SEG_MASK) == `XBED_SEG_PAT) begin
               segovr_q <= 1'b1;
               segsel_q <= byte_in[4:3];
            end
            if (byte_in == `XBED_OP_LOCK || (byte_in & `XBED_SEG_MASK) == `XBED_SEG_PAT)
               wait_q <= `XBED_T_LOCK;
         end
         if (state_q == S_MODRM && take) begin
            modrm_q <= byte_in;
            dlo_q   <= 8'h00;
            dhi_q   <= 8'h00;
         end
         if ((state_q == S_DLO || state_q == S_DISP8) && take)
            dlo_q <= byte_in;
         if (state_q == S_DHI && take)
            dhi_q <= byte_in;
         if (state_q == S_WAIT)
            wait_q <= wait_q - 8'h01;
         // hold one clock in S_WAIT after the closing byte, whatever count is charged
         if (fin)
            wait_q <= 8'h01;
      end
   end

   // --------------------------------------------------------------
   // results, registered as the wait state after the closing byte ends
   // --------------------------------------------------------------
   // trap decision is taken from the flag level at completion
   wire       intt = of_in;
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         done_out       <= 1'b0;
         opcode_out     <= 8'h00;
         clocks_out     <= 8'h00;
         taken_out      <= 1'b0;
         disp_out       <= 16'h0000;
         cx_we_out      <= 1'b0;
         cx_new_out     <= 16'h0000;
         interrupt_on_overflow_trap_out  <= 1'b0;
         bound_trap_out <= 1'b0;
         lock_out       <= 1'b0;
         ea_out         <= 16'h0000;
         seg_out        <= 2'h0;
         rm_is_reg_out  <= 1'b0;
         reg_sel_out    <= 4'h0;
         rm_sel_out     <= 4'h0;
      end else begin
         done_out       <= 1'b0;
         cx_we_out      <= 1'b0;
         interrupt_on_overflow_trap_out  <= 1'b0;
         bound_trap_out <= 1'b0;
         if (state_q == S_WAIT && wait_q <= 8'h01 && op_q != `XBED_OP_LOCK &&
             (op_q & `XBED_SEG_MASK) != `XBED_SEG_PAT) begin
            done_out <= 1'b1;
            lock_out <= lock_q;
            if (is_br) begin
               // first count not taken, second taken
               taken_out  <= br_tk;
               clocks_out <= br_tk ? br_t : br_nt;
               disp_out   <= {{8{dlo_q[7]}}, dlo_q};
               cx_we_out  <= (op_q[7:2] == 6'h38) && (op_q != `XBED_OP_JCZ);
               cx_new_out <= cx_dec;
            end else if (op_q == `XBED_OP_INTOVF) begin
               taken_out     <= intt;
               interrupt_on_overflow_trap_out <= intt;
               clocks_out    <= intt ? `XBED_T_INTERRUPT_ON_OVERFLOW_TK : `XBED_T_INTERRUPT_ON_OVERFLOW_NT;
            end else if (op_q == `XBED_OP_BOUND) begin
               // address time is inside the listed count, not added
               clocks_out     <= bnd_clk;
               bound_trap_out <= bnd_out;
               taken_out      <= bnd_out;
               ea_out         <= ea_w;
               rm_is_reg_out  <= isreg_w;
               reg_sel_out    <= {byte_op_in & modrm_q[5], modrm_q[5:3] &
                                  {~byte_op_in, 2'h3}};
               rm_sel_out     <= {byte_op_in & modrm_q[2], modrm_q[2:0] &
                                  {~byte_op_in, 2'h3}};
               if (string_dst_in)
                  seg_out <= `XBED_SEG_ES;
               else if (segovr_q)
                  seg_out <= segsel_q;
               else
                  seg_out <= seg_w;
            end else begin
               taken_out  <= 1'b0;
               clocks_out <= `XBED_T_OTHER;
            end
            opcode_out <= op_q;
         end
      end
   end
endmodule // xbed_decoder

// [xbed_decoder_asserts.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the branch / address decoder
// ----------------------------------------------------------------
module xbed_decoder_chk (
   input logic        clk_in,          // clock
   input logic        rstn_in,         // reset, active low
   input logic        byte_valid_in,   // byte offered
   input logic        byte_ready_out,  // byte accepted
   input logic [15:0] cx_in,           // count register
   input logic [15:0] bound_val_in,    // value under check
   input logic [15:0] bound_lo_in,     // lower bound
   input logic [15:0] bound_hi_in,     // upper bound
   input logic        zf_in,           // zero flag
   input logic        of_in,           // overflow flag
   input logic        string_dst_in,   // string destination
   input logic        byte_op_in,      // byte operation
   input logic        done_out,        // completion pulse
   input logic [7:0]  opcode_out,      // opcode
   input logic [7:0]  clocks_out,      // clocks charged
   input logic        taken_out,       // taken
   input logic [15:0] disp_out,        // displacement
   input logic        cx_we_out,       // count write
   input logic [15:0] cx_new_out,      // new count
   input logic        interrupt_on_overflow_trap_out,   // overflow trap
   input logic        bound_trap_out,  // range trap
   input logic [1:0]  seg_out,         // segment
   input logic        rm_is_reg_out,   // register operand
   input logic [3:0]  reg_sel_out      // register select
);
   // single domain, so clock and reset are given once
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // bounds completions
   wire bnd = done_out && opcode_out == 8'h62;

   done_gap_a: assert property (done_out |-> $past(!byte_ready_out) &&
      $past(byte_valid_in && byte_ready_out, 2)) else $error("done not two after last byte");
   done_one_a: assert property (done_out |=> !done_out)
      else $error("done wider than one");
   jcc_time_a: assert property (done_out &&
      (opcode_out == 8'h71 || opcode_out == 8'h79)
      |-> clocks_out == (taken_out ? 8'h0D : 8'h04) && disp_out[15:8] == {8{disp_out[7]}})
      else $error("short jump clocks or displacement wrong");
   jcz_time_a: assert property (done_out && opcode_out == 8'hE3 |->
      taken_out == ($past(cx_in) == 16'h0000) && clocks_out == (taken_out ? 8'h0F : 8'h05))
      else $error("count zero jump wrong");
   loop_cnt_a: assert property (done_out && opcode_out == 8'hE2 |-> cx_we_out &&
      cx_new_out == $past(cx_in) - 16'h0001 && taken_out == (cx_new_out != 16'h0000)
      && clocks_out == (taken_out ? 8'h10 : 8'h06)) else $error("loop wrong");
   loop_flag_a: assert property (done_out &&
      (opcode_out == 8'hE0 || opcode_out == 8'hE1) |-> cx_we_out &&
      clocks_out == (taken_out ? 8'h10 : 8'h06) && taken_out == (cx_new_out != 16'h0000 &&
      $past(zf_in) == opcode_out[0])) else $error("flag loop wrong");
   ovf_trap_a: assert property (done_out && opcode_out == 8'hCE |-> interrupt_on_overflow_trap_out ==
      $past(of_in) && clocks_out == (interrupt_on_overflow_trap_out ? 8'h30 : 8'h04)) else $error("trap wrong");
   no_pulse_a: assert property (!done_out |-> !cx_we_out && !interrupt_on_overflow_trap_out &&
      !bound_trap_out) else $error("pulse outside completion");
   bound_chk_a: assert property (bnd |->
      (clocks_out == 8'h21 || clocks_out == 8'h23) &&
      bound_trap_out == ($signed($past(bound_val_in)) < $signed($past(bound_lo_in)) ||
      $signed($past(bound_val_in)) > $signed($past(bound_hi_in)))) else $error("bounds wrong");
   str_seg_a: assert property (bnd && !rm_is_reg_out && $past(string_dst_in)
      |-> seg_out == 2'h0) else $error("string destination segment wrong");
   byte_sel_a: assert property (bnd && $past(byte_op_in) |-> !reg_sel_out[2])
      else $error("byte register index wrong");
endmodule // xbed_decoder_chk

bind xbed_decoder xbed_decoder_chk xbed_decoder_chk_i (.*);

// [xbed_prog_mem.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// program memory byte source, prompt or with gaps
// ----------------------------------------------------------------
module xbed_prog_mem (
   input  logic       clk_in,          // clock
   input  logic       rstn_in,         // reset, active low
   input  logic       byte_ready_in,   // decoder takes byte
   input  logic       slow_in,         // idle one cycle after each byte
   output logic [7:0] byte_out,        // instruction byte
   output logic       byte_valid_out   // byte present
);
   logic [7:0] q[$];
   logic       took = 1'b0;
   initial byte_out = 8'h00;
   initial byte_valid_out = 1'b0;
   // bytes go out in program order, displacement after the mode byte
   task push(input logic [7:0] b);
      q.push_back(b);
   endtask
   // handshake seen at the sampling edge
   always @(posedge clk_in) took <= byte_valid_out & byte_ready_in;
   // idle line toggles so a stale byte can never pass for a fresh one
   always @(negedge clk_in) begin
      if (took) void'(q.pop_front());
      if (!rstn_in || q.size() == 0 || (slow_in && took)) begin
         byte_valid_out <= 1'b0;
         byte_out <= ~byte_out;
      end else begin
         byte_valid_out <= 1'b1;
         byte_out <= q[0];
      end
   end
endmodule // xbed_prog_mem

// [x86_branch_ea_decoder_bench.sv]
`timescale 1ns/1ps
`include "xbed_regs.vh"
// ----------------------------------------------------------------
// decoder testbench
// ----------------------------------------------------------------
module x86_branch_ea_decoder_bench;
   logic clk_in = 0, rstn_in = 0, zf_in = 0, of_in = 0, sf_in = 0, slow = 0;
   logic string_dst_in = 0, byte_op_in = 0, byte_valid, byte_ready, done_out;
   logic [7:0] byte_b, opcode_out, clocks_out;
   logic [15:0] cx_in = 0, bound_val_in = 0, bound_lo_in = 0, bound_hi_in = 0;
   logic [15:0] bx_in = 16'h1000, bp_in = 16'h2000, si_in = 16'h0030, di_in = 16'h0004;
   logic [15:0] disp_out, cx_new_out, ea_out;
   logic taken_out, cx_we_out, interrupt_on_overflow_trap_out, bound_trap_out, lock_out, rm_is_reg_out;
   logic [1:0] seg_out;
   logic [3:0] reg_sel_out, rm_sel_out;
   int n_fail = 0, checked = 0;

   xbed_prog_mem xbed_prog_mem_i (.clk_in, .rstn_in, .byte_ready_in(byte_ready),
      .slow_in(slow), .byte_out(byte_b), .byte_valid_out(byte_valid));
   xbed_decoder xbed_decoder_i (.clk_in, .rstn_in, .byte_in(byte_b), .byte_valid_in(byte_valid),
      .byte_ready_out(byte_ready), .cx_in, .bx_in, .bp_in, .si_in, .di_in, .bound_val_in,
      .bound_lo_in, .bound_hi_in, .zf_in, .of_in, .sf_in, .string_dst_in, .byte_op_in,
      .done_out, .opcode_out, .clocks_out, .taken_out, .disp_out, .cx_we_out, .cx_new_out,
      .interrupt_on_overflow_trap_out, .bound_trap_out, .lock_out, .ea_out, .seg_out, .rm_is_reg_out,
      .reg_sel_out, .rm_sel_out);

   initial forever #50 clk_in = ~clk_in;

   task finish_test;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // completion is bounded so a silent decoder cannot hang the run
   task wait_done;
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge clk_in); #1;
         if (done_out === 1'b1) break;
      end
      chk("done", 16'h0001, {15'h0000, done_out});
   endtask
   task push_n(input logic [31:0] b, input int n);
      for (int i = n - 1; i >= 0; i--) xbed_prog_mem_i.push(b[8*i+:8]);
   endtask
   // one branch with flags {zf, of, sf}; trap opcode has no displacement
   task br_case(input logic [7:0] op, input logic [15:0] cx, input logic [2:0] f,
                input logic [7:0] ck, input logic tk);
      @(negedge clk_in);
      cx_in = cx;
      {zf_in, of_in, sf_in} = f;
      if (op == 8'hCE) push_n({24'h000000, op}, 1);
      else push_n({16'h0000, op, 8'h80}, 2);
      wait_done;
      chk("clocks", ck, clocks_out);
      chk("taken", tk, taken_out);
      if (op == 8'hCE) chk("trap", tk, interrupt_on_overflow_trap_out);
      else chk("disp", 16'hFF80, disp_out);
   endtask
   // one bounds instruction, optional prefix, up to four bytes
   task ea_case(input logic [31:0] b, input int n, input logic [15:0] ea,
                input logic [1:0] sg);
      @(negedge clk_in);
      push_n(b, n);
      wait_done;
      chk("memory form", 16'h0000, rm_is_reg_out);
      chk("ea", ea, ea_out);
      chk("seg", sg, seg_out);
      chk("clocks", 16'h0023, clocks_out);
   endtask

   task t_branch;
      br_case(8'h71, 16'h0000, 3'b000, 8'h0D, 1'b1);
      br_case(8'h71, 16'h0000, 3'b010, 8'h04, 1'b0);
      br_case(8'h79, 16'h0000, 3'b000, 8'h0D, 1'b1);
      br_case(8'h79, 16'h0000, 3'b001, 8'h04, 1'b0);
      br_case(8'hE3, 16'h0000, 3'b000, 8'h0F, 1'b1);
      br_case(8'hE3, 16'h0001, 3'b000, 8'h05, 1'b0);
      br_case(8'hE2, 16'h0001, 3'b000, 8'h06, 1'b0);
      chk("count", 16'h0000, cx_new_out);
      br_case(8'hE2, 16'h0003, 3'b000, 8'h10, 1'b1);
      br_case(8'hE1, 16'h0003, 3'b100, 8'h10, 1'b1);
      br_case(8'hE1, 16'h0003, 3'b000, 8'h06, 1'b0);
      br_case(8'hE0, 16'h0003, 3'b000, 8'h10, 1'b1);
      br_case(8'hE0, 16'h0003, 3'b100, 8'h06, 1'b0);
      br_case(8'hCE, 16'h0000, 3'b010, 8'h30, 1'b1);
      br_case(8'hCE, 16'h0000, 3'b000, 8'h04, 1'b0);
      $display("branch test finished");
   endtask
   // lock prefix then two back-to-back jumps: only the first is locked
   task t_lock;
      @(negedge clk_in);
      {zf_in, of_in, sf_in} = 3'b000;
      push_n(32'h00F07105, 3);
      push_n(32'h00007905, 2);
      wait_done;
      chk("lock", 16'h0001, lock_out);
      chk("opcode", 16'h0071, opcode_out);
      wait_done;
      chk("lock", 16'h0000, lock_out);
      $display("lock test finished");
   endtask
   task t_ea;
      slow = 1'b1;
      ea_case(32'h00006200, 2, 16'h1030, 2'h3);
      ea_case(32'h006246FE, 3, 16'h1FFE, 2'h2);
      ea_case(32'h62063412, 4, 16'h1234, 2'h3);
      ea_case(32'h62820001, 4, 16'h2130, 2'h2);
      ea_case(32'h62831000, 4, 16'h2014, 2'h2);
      ea_case(32'h62871000, 4, 16'h1010, 2'h3);
      ea_case(32'h00624480, 3, 16'hFFB0, 2'h3);
      ea_case(32'h00266204, 3, 16'h0030, 2'h0);
      ea_case(32'h002E6205, 3, 16'h0004, 2'h1);
      ea_case(32'h00366207, 3, 16'h1000, 2'h2);
      ea_case(32'h3E6246FE, 4, 16'h1FFE, 2'h3);
      @(negedge clk_in) string_dst_in = 1'b1;
      ea_case(32'h003E6205, 3, 16'h0004, 2'h0);
      @(negedge clk_in) string_dst_in = 1'b0;
      slow = 1'b0;
      $display("address test finished");
   endtask
   // register forms, byte selectors and range trap
   task t_bound;
      @(negedge clk_in);
      {byte_op_in, bound_lo_in, bound_hi_in, bound_val_in} = {1'b1, 48'h0001000A000A};
      push_n(32'h000062FE, 2);
      wait_done;
      chk("register form", 16'h0001, rm_is_reg_out);
      chk("clocks", 16'h0021, clocks_out);
      chk("rm sel", 16'h000A, rm_sel_out);
      chk("reg sel", 16'h000B, reg_sel_out);
      chk("trap", 16'h0000, bound_trap_out);
      @(negedge clk_in);
      {byte_op_in, bound_val_in} = {1'b0, 16'h000B};
      push_n(32'h00006238, 2);
      wait_done;
      chk("reg sel", 16'h0007, reg_sel_out);
      chk("trap", 16'h0001, bound_trap_out);
      @(negedge clk_in);
      bound_val_in = 16'hFFFF;
      push_n(32'h000062C1, 2);
      wait_done;
      chk("rm sel", 16'h0001, rm_sel_out);
      chk("trap", 16'h0001, bound_trap_out);
      $display("bounds test finished");
   endtask

   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      #400000;
      n_fail++;
      $display("[ERR] watchdog expected done seen hang");
      finish_test;
   end
   initial begin
      repeat (12) @(negedge clk_in);
      rstn_in = 1'b1;
      t_branch;
      t_lock;
      t_ea;
      t_bound;
      finish_test;
   end
endmodule // x86_branch_ea_decoder_bench
